// >>> jrl_pkg.sv
// Shared constants for the JTAG RAM initialisation loader
package jrl_pkg;
  // ==========================================================
  // Memory port geometry
  localparam int MEM_BUS_W      = 18;
  localparam int DEF_DATA_W     = 18;
  localparam int DEF_ADDR_W     = 8;
  localparam int DEF_NUM_BLOCKS = 4;
  // ==========================================================
  // TAP instruction codes selecting the data or the address chain
  localparam int          IR_W       = 8;
  localparam logic [7:0]  OP_DATA    = 8'h10;
  localparam logic [7:0]  OP_ADDR    = 8'h11;
  // ==========================================================
  // Address source selection
  localparam logic        MODE_COUNT = 1'b0;
  localparam logic        MODE_TAP   = 1'b1;
endpackage

// >>> jrl_sipo.sv
// Serial-in parallel-out shift register with a bit counter
`timescale 1ns/1ps
module jrl_sipo #(
  parameter int W = 18
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Serial side
  input  wire logic         shift_en,
  input  wire logic         serial_in,
  input  wire logic         clear,
  // Parallel side
  output logic [W-1:0]      word,
  output logic              full
);
  localparam int CW = $clog2(W + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(W);

  logic [CW-1:0] count_q;

  // A one-bit chain would need a different shift expression
  if (W < 2) begin : g_bad_width
    $error("jrl_sipo: width must be at least two");
  end

  // ==========================================================
  // Shifter, first bit lands in the low end once W bits are in
  always_ff @(posedge clk) begin
    if (shift_en) begin
      word <= {serial_in, word[W-1:1]};
    end
  end

  // ==========================================================
  // Bit count saturates so that over-long scans still read as full
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      count_q <= '0;
    end else if (shift_en && count_q != FULL_CNT) begin
      count_q <= count_q + CW'(1);
    end
  end

  assign full = (count_q == FULL_CNT);
endmodule

// >>> jrl_loader.sv
// JTAG-fed RAM initialisation loader, top level
`timescale 1ns/1ps
// How it works
// - One chip-select per memory block, only one active at a time.
// - Write address names the memory cell written by the current write.
// - Data arrives bit-serially from the tap and leaves as a parallel word.
// - Loader drives the write clock; data, address and selects are synchronous to it.
// - Shift register width equals the RAM data width.
// - Serial bits are captured on the tap data clock, not the core clock.
// - A word is transferred only after all its bits have been shifted in.
// - Shift register output is pipelined to align with address and write clock.
// - Address comes from a tap-loaded shift register or an internal counter.
// - Memory data bus is eighteen bits; unused upper bits are driven low.
module jrl_loader
  import jrl_pkg::*;
#(
  parameter int DATA_W     = DEF_DATA_W,
  parameter int ADDR_W     = DEF_ADDR_W,
  parameter int NUM_BLOCKS = DEF_NUM_BLOCKS
) (
  // Core clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // User tap macro side
  input  wire logic                  tap_data_clock,
  input  wire logic                  tap_reset_n,
  input  wire logic                  tap_serial_data_out,
  input  wire logic                  tap_shift_dr,
  input  wire logic                  tap_update_dr,
  input  wire logic [IR_W-1:0]       tap_ir,
  // Address source strap
  input  wire logic                  addr_mode,
  // Memory write port
  output logic [MEM_BUS_W-1:0]       mem_write_data,
  output logic [ADDR_W-1:0]          mem_write_addr,
  output logic [NUM_BLOCKS-1:0]      mem_block_sel,
  output logic                       mem_write_clock
);
  localparam int BLK_W = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;
  localparam int AW_T  = ADDR_W + BLK_W;

  // Refused at elaboration: the data chain needs two bits and must fit the bus
  if (DATA_W < 2 || DATA_W > MEM_BUS_W) begin : g_bad_data_w
    $error("jrl_loader: DATA_W out of range");
  end
  if (ADDR_W < 1 || NUM_BLOCKS < 1) begin : g_bad_geom
    $error("jrl_loader: bad geometry");
  end

  function automatic logic [NUM_BLOCKS-1:0] blk_onehot(input logic [BLK_W-1:0] idx);
    blk_onehot = '0;
    blk_onehot[idx] = 1'b1;
  endfunction

  // ==========================================================
  // Tap clock domain: chains, holding words and event toggles
  logic [DATA_W-1:0] dchain;
  logic [AW_T-1:0]   achain;
  logic              dfull;
  logic              afull;
  logic              sel_data;
  logic              sel_addr;
  logic [DATA_W-1:0] dhold_q;
  logic [AW_T-1:0]   ahold_q;
  logic              dtog_q;
  logic              atog_q;

  assign sel_data = (tap_ir == OP_DATA);
  assign sel_addr = (tap_ir == OP_ADDR);

  jrl_sipo #(.W(DATA_W)) u_data_chain (
    .clk       (tap_data_clock),
    .rst_n     (tap_reset_n),
    .shift_en  (tap_shift_dr && sel_data),
    .serial_in (tap_serial_data_out),
    .clear     (tap_update_dr && sel_data),
    .word      (dchain),
    .full      (dfull)
  );

  jrl_sipo #(.W(AW_T)) u_addr_chain (
    .clk       (tap_data_clock),
    .rst_n     (tap_reset_n),
    .shift_en  (tap_shift_dr && sel_addr),
    .serial_in (tap_serial_data_out),
    .clear     (tap_update_dr && sel_addr),
    .word      (achain),
    .full      (afull)
  );

  // Partial scans are dropped rather than written as a torn word
  always_ff @(posedge tap_data_clock) begin
    if (!tap_reset_n) begin
      dtog_q <= 1'b0;
    end else if (tap_update_dr && sel_data && dfull) begin
      dhold_q <= dchain;
      dtog_q  <= ~dtog_q;
    end
  end

  always_ff @(posedge tap_data_clock) begin
    if (!tap_reset_n) begin
      atog_q <= 1'b0;
    end else if (tap_update_dr && sel_addr && afull) begin
      ahold_q <= achain;
      atog_q  <= ~atog_q;
    end
  end

  // ==========================================================
  // Crossing: toggles through two flops, held words read only after
  logic [2:0] dsync_q;
  logic [2:0] async_q;
  logic [1:0] msync_q;
  logic       devt;
  logic       aevt;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dsync_q <= 3'h0;
      async_q <= 3'h0;
      msync_q <= 2'h0;
    end else begin
      dsync_q <= {dsync_q[1:0], dtog_q};
      async_q <= {async_q[1:0], atog_q};
      msync_q <= {msync_q[0], addr_mode};
    end
  end

  assign devt = dsync_q[2] ^ dsync_q[1];
  assign aevt = async_q[2] ^ async_q[1];

  // ==========================================================
  // Write sequencer
  typedef enum logic [1:0] {JRL_IDLE, JRL_SETUP, JRL_STROBE} jrl_state_t;
  jrl_state_t      state_q;
  logic            pend_q;
  logic [BLK_W-1:0] blk_q;
  logic            go;
  logic            last_addr;

  assign go        = (devt || pend_q) && state_q == JRL_IDLE;
  assign last_addr = (mem_write_addr == {ADDR_W{1'b1}});

  // A word landing mid-write waits here; the set beats the clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pend_q <= 1'b0;
    end else if (devt && state_q != JRL_IDLE) begin
      pend_q <= 1'b1;
    end else if (go) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= JRL_IDLE;
    end else begin
      unique case (state_q)
        JRL_IDLE:   if (go) state_q <= JRL_SETUP;
        JRL_SETUP:  state_q <= JRL_STROBE;
        JRL_STROBE: state_q <= JRL_IDLE;
      endcase
    end
  end

  // Pipeline stage aligns the word with address and strobe
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mem_write_data <= '0;
    end else if (go) begin
      mem_write_data <= MEM_BUS_W'(dhold_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mem_write_clock <= 1'b0;
    end else begin
      mem_write_clock <= (state_q == JRL_SETUP);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mem_block_sel <= '0;
    end else if (go) begin
      mem_block_sel <= blk_onehot(blk_q);
    end else if (state_q == JRL_STROBE) begin
      mem_block_sel <= '0;
    end
  end

  // Address and block index; a tap load overrides the counter
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mem_write_addr <= '0;
      blk_q          <= '0;
    end else if (aevt && msync_q[1] == MODE_TAP) begin
      mem_write_addr <= ahold_q[ADDR_W-1:0];
      blk_q          <= ahold_q[AW_T-1:ADDR_W];
    end else if (state_q == JRL_STROBE && msync_q[1] == MODE_COUNT) begin
      mem_write_addr <= mem_write_addr + ADDR_W'(1);
      if (last_addr) begin
        blk_q <= (blk_q == BLK_W'(NUM_BLOCKS - 1)) ? '0 : blk_q + BLK_W'(1);
      end
    end
  end

  // ==========================================================
  // Checks
  sel_onehot_a: assert property (@(posedge mclk) disable iff (!resetn)
    $onehot0(mem_block_sel)) else $error("more than one block selected");
  sel_strobe_a: assert property (@(posedge mclk) disable iff (!resetn)
    mem_write_clock |-> $onehot(mem_block_sel) && $past(mem_block_sel) == mem_block_sel)
    else $error("select not held across write strobe");
  sel_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(mem_write_clock) |-> mem_block_sel == '0) else $error("select outlives write");
  strobe_pulse_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(mem_write_clock) |=> !mem_write_clock) else $error("strobe longer than a cycle");
  data_stable_a: assert property (@(posedge mclk) disable iff (!resetn)
    mem_write_clock |-> $stable(mem_write_data) && $stable(mem_write_addr))
    else $error("data or address moved during strobe");
  upper_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
    (mem_write_data >> DATA_W) == '0) else $error("unused data bits not low");
  write_latency_a: assert property (@(posedge mclk) disable iff (!resetn)
    go |=> !mem_write_clock ##1 mem_write_clock) else $error("word not written two cycles on");
  addr_step_a: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(mem_write_clock) && $past(msync_q[1]) == MODE_COUNT && !$past(aevt)
    |-> mem_write_addr == ADDR_W'($past(mem_write_addr) + ADDR_W'(1)))
    else $error("address counter did not step");
  full_word_a: assert property (@(posedge tap_data_clock) disable iff (!tap_reset_n)
    tap_update_dr && sel_data && !dfull |=> $stable(dtog_q)) else $error("partial word passed");

  write_seen_c:  cover property (@(posedge mclk) disable iff (!resetn) $rose(mem_write_clock));
  pend_seen_c:   cover property (@(posedge mclk) disable iff (!resetn) pend_q && go);
  block_wrap_c:  cover property (@(posedge mclk) disable iff (!resetn)
    state_q == JRL_STROBE && last_addr);
  tap_addr_c:    cover property (@(posedge mclk) disable iff (!resetn)
    aevt && msync_q[1] == MODE_TAP);
endmodule

// >>> jrl_tap_model.sv
// Behavioural model of the user tap macro feeding the loader
`timescale 1ns/1ps
module jrl_tap_model (
  // Tap clock and reset
  output logic       tck,
  output logic       trst_n,
  // Chain control and data
  output logic       tdo,
  output logic       shift,
  output logic       update,
  output logic [7:0] ir
);
  // ==========================================================
  // Idle state: clock parked low, reset released, data line, shift and update low, ir zero
  initial begin
    tck = 1'b0;
    trst_n = 1'b1;
    tdo = 1'b0;
    shift = 1'b0;
    update = 1'b0;
    ir = 8'h00;
  end
  // One 6 ns tap clock, signals change only after the falling edge
  task automatic tick();
    #3 tck = 1'b1;
    #3 tck = 1'b0;
  endtask
  task automatic reset();
    trst_n = 1'b0;
    tick();
    tick();
    trst_n = 1'b1;
  endtask
  // Host loads the instruction, shifts n bits LSB first, then updates
  task automatic send(input logic [7:0] op, input logic [31:0] v, input int n);
    ir = op;
    for (int i = 0; i < n; i++) begin
      tdo = v[i];
      shift = 1'b1;
      tick();
    end
    shift = 1'b0;
    update = 1'b1;
    tick();
    update = 1'b0;
    tdo = ~tdo;
  endtask
endmodule

// >>> jrl_loader_tb_top.sv
// Self-checking testbench for the JTAG RAM initialisation loader
`timescale 1ns/1ps
module jrl_loader_tb_top;
  import jrl_pkg::*;
  // ==========================================================
  // Narrow word and short address so upper-bit fill and block wrap show
  localparam int DW = 12;
  localparam int AW = 3;
  localparam int NB = 4;
  typedef struct {
    logic [MEM_BUS_W-1:0] d;
    logic [AW-1:0]        a;
    logic [NB-1:0]        s;
  } jrl_exp_t;
  logic                 mclk;
  logic                 resetn;
  logic                 addr_mode;
  logic                 tck;
  logic                 trst_n;
  logic                 tdo;
  logic                 shift;
  logic                 update;
  logic [7:0]           ir;
  logic [MEM_BUS_W-1:0] mem_write_data;
  logic [AW-1:0]        mem_write_addr;
  logic [NB-1:0]        mem_block_sel;
  logic                 mem_write_clock;
  logic                 wclk_q;
  jrl_exp_t             q[$];
  jrl_exp_t             e;
  int                   fails;
  int                   check_count;
  int                   exp_addr;
  int                   exp_blk;
  // ==========================================================
  jrl_tap_model i_tap (.tck(tck), .trst_n(trst_n), .tdo(tdo), .shift(shift),
    .update(update), .ir(ir));
  jrl_loader #(.DATA_W(DW), .ADDR_W(AW), .NUM_BLOCKS(NB)) i_dut (
    .mclk(mclk), .resetn(resetn), .tap_data_clock(tck), .tap_reset_n(trst_n),
    .tap_serial_data_out(tdo), .tap_shift_dr(shift), .tap_update_dr(update),
    .tap_ir(ir), .addr_mode(addr_mode), .mem_write_data(mem_write_data),
    .mem_write_addr(mem_write_addr), .mem_block_sel(mem_block_sel),
    .mem_write_clock(mem_write_clock));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic err(input string m);
    $display("ERROR %0t: %s", $time, m);
    fails++;
  endtask
  task automatic final_report();
    $display("TB: checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Monitor: every rising write clock consumes the oldest note
  always @(posedge mclk) begin
    if (mem_write_clock === 1'b1 && wclk_q === 1'b0) begin
      if (q.size() == 0) begin
        err("write with nothing expected");
      end else begin
        e = q.pop_front();
        check_count++;
        if (mem_write_data !== e.d || mem_write_addr !== e.a || mem_block_sel !== e.s) begin
          err("write port mismatch");
        end
      end
    end
    if (mem_write_clock === 1'b0 && wclk_q === 1'b1 && mem_block_sel !== '0) begin
      err("select held past write");
    end
    wclk_q <= mem_write_clock;
  end
  // Send one scan; full data scans note the last DW bits at the current address
  task automatic word(input logic [7:0] op, input logic [31:0] v, input int n);
    int k;
    i_tap.send(op, v, n);
    if (op == OP_DATA && n >= DW) begin
      q.push_back('{MEM_BUS_W'(DW'(v >> (n - DW))), AW'(exp_addr), NB'(1 << exp_blk)});
      if (addr_mode == MODE_COUNT) begin
        exp_addr++;
        if (exp_addr == (1 << AW)) begin
          exp_addr = 0;
          exp_blk = (exp_blk + 1) % NB;
        end
      end
    end
    k = 0;
    while (q.size() != 0 && k < 60) begin
      @(negedge mclk);
      k++;
    end
    if (q.size() != 0) err("write never came");
    repeat (8) @(negedge mclk);
  endtask
  // ==========================================================
  initial begin
    resetn = 1'b0;
    addr_mode = MODE_COUNT;
    void'($urandom(4397));
    i_tap.reset();
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    // Counter addressing across an address wrap into the next block
    for (int i = 0; i < 9; i++) word(OP_DATA, $urandom, DW);
    $display("TB: test counter done");
    // Short scan dropped, foreign opcode ignored, long scan keeps last bits
    word(OP_DATA, $urandom, DW - 1);
    word(8'h5a, $urandom, DW);
    word(OP_DATA, $urandom, DW + 3);
    $display("TB: test scans done");
    // Tap-loaded address and block, held across back-to-back words
    @(negedge mclk);
    addr_mode = MODE_TAP;
    repeat (6) @(negedge mclk);
    i_tap.send(OP_ADDR, 32'h15, AW + 2);
    repeat (10) @(negedge mclk);
    exp_addr = 5;
    exp_blk = 2;
    for (int i = 0; i < 2; i++) word(OP_DATA, $urandom, DW);
    $display("TB: test tap address done");
    final_report();
  end
  initial begin
    #40000;
    err("watchdog expired");
    final_report();
  end
endmodule
